// *** common/odd_pkg.sv ***
// Constants shared by the octal driver diagnostic register logic
package odd_pkg;
   // Serial frame layout
   localparam int unsigned   ODD_FRAME_BITS   = 24;
   localparam int unsigned   ODD_CMD_WR_BIT   = 23;
   localparam int unsigned   ODD_ADDR_MSB     = 19;
   localparam int unsigned   ODD_ADDR_LSB     = 16;
   localparam int unsigned   ODD_DATA_MSB     = 15;
   localparam int unsigned   ODD_DATA_LSB     = 8;
   localparam logic [4:0]    ODD_CNT_FULL     = 5'h18;
   localparam logic [4:0]    ODD_CNT_MAX      = 5'h1F;
   // Register addresses
   localparam logic [3:0]    ODD_A_DRIVE      = 4'h0;
   localparam logic [3:0]    ODD_A_DRIVE_RSY  = 4'h1;
   localparam logic [3:0]    ODD_A_COLLECTED  = 4'h2;
   localparam logic [3:0]    ODD_A_GLOBAL_ERR = 4'h3;
   localparam logic [3:0]    ODD_A_CHK_CFG    = 4'h4;
   localparam logic [3:0]    ODD_A_INT_ERR    = 4'h5;
   localparam logic [3:0]    ODD_A_GLOBAL_SET = 4'h6;
   localparam logic [3:0]    ODD_A_DETAIL0    = 4'h8;
   // Internal error register fields
   localparam int unsigned   ODD_IE_TE        = 0;
   localparam int unsigned   ODD_IE_WS        = 1;
   localparam int unsigned   ODD_IE_ALL_OUTPUTS_OFF_FLAG    = 2;
   // Global error register fields
   localparam int unsigned   ODD_GE_CF        = 0;
   localparam int unsigned   ODD_GE_MV        = 1;
   localparam int unsigned   ODD_GE_UV        = 2;
   localparam int unsigned   ODD_GE_WP        = 3;
   // Channel detail field: open load while switched on
   localparam int unsigned   ODD_DT_OLA       = 2;
   // Reset values
   localparam logic [2:0]    ODD_IE_RST       = 3'h7;
   localparam logic          ODD_GE_FLAG_RST  = 1'b1;
   localparam logic [7:0]    ODD_BYTE_RST     = 8'h00;
   localparam logic [23:0]   ODD_RESP_RST     = 24'h000000;
   // Response check bits
   localparam logic [5:0]    ODD_CRC_POLY     = 6'h03;
   localparam logic [5:0]    ODD_CRC_INIT     = 6'h3F;
endpackage : odd_pkg

// *** common/odd_ser_if.sv ***
// Link between the serial shifter and the register core
`timescale 1ns/1ps
interface odd_ser_if;
   logic        frame_done;
   logic        frame_bad;
   logic [23:0] rx_word;
   logic [23:0] tx_word;
   modport ser  (output frame_done, frame_bad, rx_word, input tx_word);
   modport core (input frame_done, frame_bad, rx_word, output tx_word);
endinterface : odd_ser_if

// *** rtl/odd_serial.sv ***
// Serial frame shifter sampling the link pins with the system clock
`timescale 1ns/1ps
module odd_serial (
   // Clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   // Link pins
   input  wire logic   i_sclk,
   input  wire logic   i_cs_n,
   input  wire logic   i_mosi,
   output logic        o_miso,
   output logic        o_miso_oe,
   // Core side
   odd_ser_if.ser      bus
);
   import odd_pkg::*;

   logic [2:0]  s1_q, s2_q;
   logic        sck_prev_q, cs_prev_q;
   logic [4:0]  cnt_q, cnt_d;
   logic [23:0] rx_q, rx_d, tx_q, tx_d;
   logic        miso_q, miso_d, oe_q, oe_d;
   logic        done_q, done_d, bad_q, bad_d;
   logic        sck_s, cs_n_s, mosi_s;

   assign sck_s  = s2_q[2];
   assign cs_n_s = s2_q[1];
   assign mosi_s = s2_q[0];

   // Pin synchronisers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q       <= 3'h2;
         s2_q       <= 3'h2;
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         s1_q       <= {i_sclk, i_cs_n, i_mosi};
         s2_q       <= s1_q;
         sck_prev_q <= sck_s;
         cs_prev_q  <= cs_n_s;
      end
   end

   // Shift on rising edge in, falling edge out
   always_comb begin
      cnt_d  = cnt_q;
      rx_d   = rx_q;
      tx_d   = tx_q;
      miso_d = miso_q;
      oe_d   = oe_q;
      done_d = 1'b0;
      bad_d  = 1'b0;
      if (cs_prev_q && !cs_n_s) begin
         cnt_d  = 5'h00;
         tx_d   = bus.tx_word;
         miso_d = bus.tx_word[23];
         oe_d   = 1'b1;
      end else if (!cs_n_s) begin
         if (!sck_prev_q && sck_s) begin
            rx_d = {rx_q[22:0], mosi_s};
            if (cnt_q != ODD_CNT_MAX) begin
               cnt_d = cnt_q + 5'h01;
            end
         end
         if (sck_prev_q && !sck_s) begin
            tx_d   = {tx_q[22:0], 1'b0};
            miso_d = tx_q[22];
         end
      end else if (!cs_prev_q) begin
         oe_d   = 1'b0;
         miso_d = 1'b0;
         if (cnt_q == ODD_CNT_FULL) begin
            done_d = 1'b1;
         end else begin
            bad_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q  <= 5'h00;
         rx_q   <= ODD_RESP_RST;
         tx_q   <= ODD_RESP_RST;
         miso_q <= 1'b0;
         oe_q   <= 1'b0;
         done_q <= 1'b0;
         bad_q  <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         rx_q   <= rx_d;
         tx_q   <= tx_d;
         miso_q <= miso_d;
         oe_q   <= oe_d;
         done_q <= done_d;
         bad_q  <= bad_d;
      end
   end

   assign o_miso         = miso_q;
   assign o_miso_oe      = oe_q;
   assign bus.rx_word    = rx_q;
   assign bus.frame_done = done_q;
   assign bus.frame_bad  = bad_q;
endmodule : odd_serial

// *** rtl/odd_regs.sv ***
// Diagnostic and output-control registers of an eight-channel driver
`timescale 1ns/1ps
module odd_regs #(
   parameter int unsigned N_CH = 8
) (
   // Clock and reset
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_RST,
   // Serial link
   input  wire logic              I_SCLK,
   input  wire logic              I_CS_N,
   input  wire logic              I_MOSI,
   output logic                   O_MISO,
   output logic                   O_MISO_OE,
   // Fault conditions and disable pin
   input  wire logic              I_OUTPUT_DISABLE_N,
   input  wire logic              I_UNDERVOLTAGE,
   input  wire logic              I_MISSING_SUPPLY,
   input  wire logic              I_WAIT_POWER,
   input  wire logic              I_WAIT_SENSE,
   input  wire logic [N_CH-1:0]   I_OPEN_LOAD,
   // Outputs and status
   output logic [N_CH-1:0]        O_DRIVE,
   output logic                   O_FAULT_N,
   output logic [7:0]             O_GLOBAL_SETTINGS
);
   import odd_pkg::*;

   odd_ser_if ser_bus ();

   odd_serial u_serial (
      .i_clk     (I_CLK_SYS),
      .i_rst     (I_RST),
      .i_sclk    (I_SCLK),
      .i_cs_n    (I_CS_N),
      .i_mosi    (I_MOSI),
      .o_miso    (O_MISO),
      .o_miso_oe (O_MISO_OE),
      .bus       (ser_bus.ser)
   );

   localparam int unsigned NP = N_CH + 5;

   logic [NP-1:0]   p1_q, p2_q;
   logic            output_disable_pin_n_s, uv_s, mv_s, wp_s, ws_s;
   logic [N_CH-1:0] ol_s;

   // Condition synchronisers
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         p1_q <= '0;
         p2_q <= '0;
      end else begin
         p1_q <= {I_OUTPUT_DISABLE_N, I_UNDERVOLTAGE, I_MISSING_SUPPLY,
                  I_WAIT_POWER, I_WAIT_SENSE, I_OPEN_LOAD};
         p2_q <= p1_q;
      end
   end
   assign {output_disable_pin_n_s, uv_s, mv_s, wp_s, ws_s, ol_s} = p2_q;

   logic [N_CH-1:0] drive_q, drive_d, cfg_q, cfg_d, out_q, out_d;
   logic [7:0]      gset_q, gset_d;
   logic [2:0]      ie_q, ie_d;
   logic            uv_q, uv_d, mv_q, mv_d, wp_q, wp_d;
   logic [23:0]     resp_q, resp_d;
   logic            fault_n_q, fault_n_d;
   logic [7:0]      det_q [N_CH];
   logic [7:0]      det_d [N_CH];
   logic [N_CH-1:0] collected;
   logic            cf;
   logic            wr, rd, rd_ie, rd_ge;
   logic [3:0]      addr;
   logic [7:0]      wdata, rdata;
   logic [7:0]      ge_val;
   logic [7:0]      byte0;

   assign wr    = ser_bus.frame_done & ser_bus.rx_word[ODD_CMD_WR_BIT];
   assign rd    = ser_bus.frame_done & ~ser_bus.rx_word[ODD_CMD_WR_BIT];
   assign addr  = ser_bus.rx_word[ODD_ADDR_MSB:ODD_ADDR_LSB];
   assign wdata = ser_bus.rx_word[ODD_DATA_MSB:ODD_DATA_LSB];
   assign rd_ie = rd && addr == ODD_A_INT_ERR;
   assign rd_ge = rd && addr == ODD_A_GLOBAL_ERR;
   assign out_d = output_disable_pin_n_s ? drive_q : '0;

   // Per-channel detail and collected bit
   for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
      logic ola;
      logic rd_det;
      assign collected[ch] = |det_q[ch];
      always_comb begin
         ola    = cfg_q[ch] & out_q[ch] & ol_s[ch];
         rd_det = rd && addr == (ODD_A_DETAIL0 + 4'(ch));
         det_d[ch] = rd_det ? 8'h00 : det_q[ch];
         det_d[ch][ODD_DT_OLA] = det_d[ch][ODD_DT_OLA] | ola;
      end
      always_ff @(posedge I_CLK_SYS) begin
         if (I_RST) begin
            det_q[ch] <= ODD_BYTE_RST;
         end else begin
            det_q[ch] <= det_d[ch];
         end
      end
   end

   assign cf = |collected;

   function automatic logic [5:0] crc6(input logic [17:0] d);
      logic [5:0] c;
      logic       fb;
      c = ODD_CRC_INIT;
      for (int i = 17; i >= 0; i--) begin
         fb = c[5] ^ d[i];
         c  = {c[4:0], 1'b0} ^ (fb ? ODD_CRC_POLY : 6'h00);
      end
      return c;
   endfunction : crc6

   always_comb begin
      ge_val = 8'h00;
      ge_val[ODD_GE_CF] = cf;
      ge_val[ODD_GE_MV] = mv_q;
      ge_val[ODD_GE_UV] = uv_q;
      ge_val[ODD_GE_WP] = wp_q;
      rdata = 8'h00;
      unique case (addr)
         ODD_A_DRIVE, ODD_A_DRIVE_RSY: rdata = 8'(drive_q);
         ODD_A_COLLECTED:  rdata = 8'(collected);
         ODD_A_GLOBAL_ERR: rdata = ge_val;
         ODD_A_CHK_CFG:    rdata = 8'(cfg_q);
         ODD_A_INT_ERR:    rdata = {5'h00, ie_q};
         ODD_A_GLOBAL_SET: rdata = gset_q;
         default: begin
            if (addr >= ODD_A_DETAIL0 &&
                32'(addr - ODD_A_DETAIL0) < N_CH) begin
               rdata = det_q[3'(addr - ODD_A_DETAIL0)];
            end
         end
      endcase
   end

   // Register update, sticky flags and response
   always_comb begin
      drive_d = drive_q;
      cfg_d   = cfg_q;
      gset_d  = gset_q;
      resp_d  = resp_q;
      byte0   = 8'(collected);
      if (wr) begin
         if (addr == ODD_A_DRIVE || addr == ODD_A_DRIVE_RSY) begin
            drive_d = N_CH'(wdata);
         end
         if (addr == ODD_A_CHK_CFG) begin
            cfg_d = N_CH'(wdata);
         end
         if (addr == ODD_A_GLOBAL_SET) begin
            gset_d = wdata;
         end
      end
      if (ser_bus.frame_done) begin
         resp_d = {byte0, rdata, uv_q, mv_q,
                   crc6({byte0, rdata, uv_q, mv_q})};
      end
      ie_d[ODD_IE_TE] = ser_bus.frame_bad |
                        (ie_q[ODD_IE_TE] & ~rd_ie);
      ie_d[ODD_IE_WS] = ws_s | (ie_q[ODD_IE_WS] & ~rd_ie);
      ie_d[ODD_IE_ALL_OUTPUTS_OFF_FLAG] = (out_q == '0) |
                            (ie_q[ODD_IE_ALL_OUTPUTS_OFF_FLAG] & ~rd_ie);
      uv_d = uv_s | (uv_q & ~(rd_ie | rd_ge));
      mv_d = mv_s | (mv_q & ~(rd_ie | rd_ge));
      wp_d = wp_s | (wp_q & ~(rd_ie | rd_ge));
      fault_n_d = ~(ie_q[ODD_IE_TE] | ie_q[ODD_IE_WS] | uv_q | mv_q |
                    wp_q);
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         drive_q   <= '0;
         cfg_q     <= '0;
         out_q     <= '0;
         gset_q    <= ODD_BYTE_RST;
         ie_q      <= ODD_IE_RST;
         uv_q      <= ODD_GE_FLAG_RST;
         mv_q      <= ODD_GE_FLAG_RST;
         wp_q      <= ODD_GE_FLAG_RST;
         resp_q    <= ODD_RESP_RST;
         fault_n_q <= 1'b0;
      end else begin
         drive_q   <= drive_d;
         cfg_q     <= cfg_d;
         out_q     <= out_d;
         gset_q    <= gset_d;
         ie_q      <= ie_d;
         uv_q      <= uv_d;
         mv_q      <= mv_d;
         wp_q      <= wp_d;
         resp_q    <= resp_d;
         fault_n_q <= fault_n_d;
      end
   end

   assign ser_bus.tx_word   = resp_q;
   assign O_DRIVE           = out_q;
   assign O_FAULT_N         = fault_n_q;
   assign O_GLOBAL_SETTINGS = gset_q;
endmodule : odd_regs

// *** sim/odd_regs_monitor.sv ***
// Port checker of the diagnostic register block
`timescale 1ns/1ps
module odd_regs_monitor #(
   parameter int unsigned N_CH = 8
) (
   // Clock and reset
   input  wire logic            I_CLK_SYS,
   input  wire logic            I_RST,
   // Link and pins
   input  wire logic            I_CS_N,
   input  wire logic            O_MISO_OE,
   input  wire logic            I_OUTPUT_DISABLE_N,
   input  wire logic            I_UNDERVOLTAGE,
   input  wire logic            I_MISSING_SUPPLY,
   input  wire logic            I_WAIT_POWER,
   input  wire logic            I_WAIT_SENSE,
   // Outputs
   input  wire logic [N_CH-1:0] O_DRIVE,
   input  wire logic            O_FAULT_N
);
   logic       cause;
   logic       cs_q;
   logic       dis_q;
   logic [7:0] cs_age;
   logic [7:0] dis_age;
   assign cause = I_UNDERVOLTAGE | I_MISSING_SUPPLY | I_WAIT_POWER
                  | I_WAIT_SENSE;
   // Cycles since the last frame end and the last disable pin change
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cs_q    <= 1'b1;
         dis_q   <= 1'b1;
         cs_age  <= 8'hFF;
         dis_age <= 8'hFF;
      end else begin
         cs_q    <= I_CS_N;
         dis_q   <= I_OUTPUT_DISABLE_N;
         cs_age  <= (I_CS_N && !cs_q) ? 8'h00 :
                    (cs_age == 8'hFF) ? cs_age : cs_age + 8'h01;
         dis_age <= (I_OUTPUT_DISABLE_N != dis_q) ? 8'h00 :
                    (dis_age == 8'hFF) ? dis_age : dis_age + 8'h01;
      end
   end
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   AST_CAUSE_PULLS_PIN: assert property (cause [*5] |-> !O_FAULT_N)
      else $error("fault pin high while a fault cause persists");
   AST_DISABLE_OFF: assert property (
      !I_OUTPUT_DISABLE_N [*5] |-> O_DRIVE == '0)
      else $error("outputs on while disable pin low");
   AST_PIN_RISE_AFTER_READ: assert property (
      $rose(O_FAULT_N) |-> cs_age <= 8'h0C)
      else $error("fault pin released without a frame");
   AST_DRIVE_HOLD: assert property (
      $changed(O_DRIVE) |-> (cs_age <= 8'h0C || dis_age <= 8'h08))
      else $error("outputs changed without write or disable");
   AST_QUIET_PIN: assert property (
      (O_FAULT_N && I_CS_N && !cause) [*8] |=> O_FAULT_N)
      else $error("fault pin fell without a contributing cause");
   AST_RESET_FAULT: assert property ($fell(I_RST) |-> !O_FAULT_N)
      else $error("fault pin not low after reset");
   AST_OE_FRAME: assert property (!I_CS_N [*5] |-> O_MISO_OE)
      else $error("response line not driven in frame");
   AST_OE_IDLE: assert property (I_CS_N [*5] |-> !O_MISO_OE)
      else $error("response line driven outside frame");
   cover property ($rose(O_FAULT_N));
   cover property ($fell(O_FAULT_N));
   cover property ($fell(O_DRIVE[0]));
endmodule : odd_regs_monitor

bind odd_regs odd_regs_monitor #(.N_CH(N_CH)) odd_regs_monitor_i (
   .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CS_N(I_CS_N),
   .O_MISO_OE(O_MISO_OE), .I_OUTPUT_DISABLE_N(I_OUTPUT_DISABLE_N),
   .I_UNDERVOLTAGE(I_UNDERVOLTAGE), .I_MISSING_SUPPLY(I_MISSING_SUPPLY),
   .I_WAIT_POWER(I_WAIT_POWER), .I_WAIT_SENSE(I_WAIT_SENSE),
   .O_DRIVE(O_DRIVE), .O_FAULT_N(O_FAULT_N));

// *** sim/odd_spi_master.sv ***
// Serial master model sending the first nb bits of a 24-bit command as one frame
`timescale 1ns/1ps
module odd_spi_master (
   // Clock
   input  wire logic i_clk,
   // Link
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // Link clock of 80 ns, stands low outside frames
   task automatic xfer(input logic [23:0] cmd, input int nb,
                       output logic [23:0] rsp);
      rsp = '0;
      tick(1);
      o_cs_n = 1'b0;
      for (int b = 0; b < nb; b++) begin
         o_mosi = cmd[23-b];
         tick(5);
         o_sclk = 1'b1;
         rsp = {rsp[22:0], i_miso};
         tick(5);
         o_sclk = 1'b0;
      end
      tick(5);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      tick(12);
   endtask : xfer
endmodule : odd_spi_master

// *** sim/odd_regs_tb.sv ***
// Self-checking bench of the register block
`timescale 1ns/1ps
module odd_regs_tb;
   import odd_pkg::*;
   logic        clk, rst, sclk, cs_n, mosi, miso, dis_n;
   logic        uv, mv, wp, ws, flt_n;
   logic [7:0]  ol, drv, gset;
   logic [23:0] resp;
   int          errors, comparisons;
   // Open load, command, byte one, byte two, supply flags
   logic [43:0] r [17] = '{
      44'h00_84FF_00_00_3, 44'h00_0500_00_07_3, 44'h00_0500_00_04_0,
      44'h00_8055_00_00_0, 44'h00_0500_00_04_0, 44'h00_0500_00_00_0,
      44'h00_0100_00_55_0, 44'h00_0400_00_FF_0, 44'h01_0000_01_55_0,
      44'h01_0300_01_01_0, 44'h01_0200_01_01_0, 44'h01_0800_01_04_0,
      44'h00_0200_01_01_0, 44'h00_0800_01_04_0, 44'h00_0800_00_00_0,
      44'h00_0300_00_00_0, 44'h00_0700_00_00_0};
   odd_regs odd_regs_i (.I_CLK_SYS(clk), .I_RST(rst), .I_SCLK(sclk),
      .I_CS_N(cs_n), .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE(),
      .I_OUTPUT_DISABLE_N(dis_n), .I_UNDERVOLTAGE(uv),
      .I_MISSING_SUPPLY(mv), .I_WAIT_POWER(wp), .I_WAIT_SENSE(ws),
      .I_OPEN_LOAD(ol), .O_DRIVE(drv), .O_FAULT_N(flt_n),
      .O_GLOBAL_SETTINGS(gset));
   odd_spi_master odd_spi_master_i (.i_clk(clk), .i_miso(miso),
      .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [23:0] word(input logic [43:0] w);
      logic [5:0]  c;
      logic [17:0] d;
      d = {w[19:4], w[1:0]};
      c = 6'h3F;
      for (int k = 17; k >= 0; k--) begin
         c = {c[4:0], 1'b0} ^ ((c[5] ^ d[k]) ? ODD_CRC_POLY : 6'h00);
      end
      return {d, c};
   endfunction : word
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic rd(input logic [23:0] c);
      odd_spi_master_i.xfer(c, 24, resp);
   endtask : rd
   task automatic wrap_up();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      dis_n = 1'b1;
      {wp, ws, mv, uv} = 4'h0;
      ol = 8'h00;
      errors = 0;
      comparisons = 0;
      cyc(10);
      rst = 1'b0;
      cyc(4);
      for (int i = 0; i <= 17; i++) begin
         if (i < 17) ol = r[i][43:36];
         rd(i < 17 ? {r[i][35:20], 8'h00} : 24'h070000);
         if (i > 0) chk(resp, word(r[i-1]));
      end
      chk(24'(flt_n), 24'h1);
      dis_n = 1'b0;
      cyc(6);
      chk(24'(drv), 24'h0);
      chk(24'(flt_n), 24'h1);
      dis_n = 1'b1;
      cyc(6);
      chk(24'(drv), 24'h55);
      // Settings write, then read; a cut frame must not disturb the reply
      rd(24'h86A500);
      rd(24'h060000);
      chk(resp, word(44'h00_0000_00_00_0));
      chk(24'(gset), 24'hA5);
      odd_spi_master_i.xfer(24'h050000, 16, resp);
      chk(24'(flt_n), 24'h0);
      rd(24'h050000);
      chk(resp, word(44'h00_0000_00_A5_0));
      chk(24'(flt_n), 24'h1);
      for (int k = 0; k < 4; k++) begin
         {wp, ws, mv, uv} = 4'h1 << k;
         cyc(8);
         chk(24'(flt_n), 24'h0);
         rd(24'h050000);
         chk(24'(flt_n), 24'h0);
         {wp, ws, mv, uv} = 4'h0;
         rd(24'h050000);
         chk(24'(flt_n), 24'h1);
      end
      rst = 1'b1;
      cyc(10);
      rst = 1'b0;
      cyc(1);
      chk(24'(flt_n), 24'h0);
      chk(24'(drv), 24'h0);
      cyc(4);
      rd(24'h050000);
      rd(24'h070000);
      chk(resp, word(44'h00_0000_00_07_3));
      wrap_up();
   end
endmodule : odd_regs_tb
